// ### rtl/tsg_cfg.svh
`ifndef TSG_CFG_SVH
`define TSG_CFG_SVH
// register byte offsets
`define TSG_OFF_CTRL 12'h000
`define TSG_OFF_CMD 12'h004
`define TSG_OFF_STATUS 12'h008
`define TSG_OFF_LEVEL 12'h00C
`define TSG_OFF_LEN 12'h010
`define TSG_OFF_STD 12'h014
`define TSG_OFF_SEQ 12'h100
`define TSG_OFF_TIME 12'h140
`define TSG_OFF_DEF 12'h180
// ctrl field positions
`define TSG_CTRL_MODE_LSB 0
`define TSG_CTRL_ROUTE_BIT 2
`define TSG_CTRL_PREEMP_BIT 3
`define TSG_CTRL_BURST_LSB 8
// cmd bits
`define TSG_CMD_SEND_BIT 0
`define TSG_CMD_STOP_BIT 1
// reset values
`define TSG_CTRL_RST 32'h0000_0100
`define TSG_LEVEL_RST 8'h00
`define TSG_LEN_RST 5'h10
// pre-emphasis time constant and derived cycles
`define TSG_PREEMP_TAU_US 750000
`define TSG_CLK_MHZ 250
`define TSG_PREEMP_CYC (`TSG_PREEMP_TAU_US * `TSG_CLK_MHZ)
// on/off time unit in microseconds and cycles
`define TSG_TICK_US 1000
`define TSG_TICK_CYC (`TSG_TICK_US * `TSG_CLK_MHZ)
`endif

// ### rtl/tsg_pkg.sv
package tsg_pkg;
    typedef enum logic [1:0] {
        TSG_SINGLE = 2'h0,
        TSG_BURST = 2'h1,
        TSG_CONT = 2'h2,
        TSG_STEP = 2'h3
    } tsg_mode_e;
    // gray codes along idle -> on -> off
    typedef enum logic [1:0] {
        TSG_IDLE = 2'b00,
        TSG_ON = 2'b01,
        TSG_OFF = 2'b11
    } tsg_state_e;
    typedef struct packed {
        logic [15:0] freq;
        logic [7:0] amp;
    } tsg_def_s;
    typedef struct packed {
        logic [15:0] on_time;
        logic [15:0] off_time;
    } tsg_time_s;
    typedef struct packed {
        logic valid;
        logic [15:0] freq;
        logic [15:0] amp;
    } tsg_tone_s;
endpackage : tsg_pkg

// ### rtl/tsg_top.sv
`timescale 1ns/1ps
`include "tsg_cfg.svh"
module tsg_top
    import tsg_pkg::*;
#(
    parameter int unsigned TICK_CYC = `TSG_TICK_CYC,
    parameter longint unsigned PREEMP_CYC = `TSG_PREEMP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output tsg_tone_s rf_mod_out,
    output tsg_tone_s audio_out,
    output logic busy
);
    localparam logic [31:0] TICK_M1 = 32'(TICK_CYC - 1);
    localparam int PE_SHIFT = (PREEMP_CYC > 64'd1) ? $clog2(PREEMP_CYC) : 1;

    logic [31:0] ctrl_reg;
    logic [7:0] level_reg;
    logic [4:0] len_reg;
    logic [3:0] seq_reg [16];
    tsg_time_s time_reg [16];
    tsg_def_s def_reg [16];
    tsg_state_e state_reg;
    logic [3:0] pos_reg;
    logic [7:0] burst_left_reg;
    logic [15:0] dur_reg;
    logic [31:0] tick_reg;
    logic [1:0] std_reg;
    logic std_load_reg;
    logic [15:0] amp_reg;
    logic [15:0] freq_reg;
    logic [31:0] pe_acc_reg;
    tsg_tone_s tone_reg;
    logic on_q_reg;

    tsg_mode_e mode;
    logic route_audio;
    logic preemp_on;
    logic wr_en;
    logic rd_en;
    logic send_cmd;
    logic stop_cmd;
    logic tick;
    logic last_pos;
    logic [3:0] cur_sym;
    logic [15:0] scaled_amp;
    logic [15:0] amp_fin;
    logic addr_ok;

    assign mode = tsg_mode_e'(ctrl_reg[`TSG_CTRL_MODE_LSB +: 2]);
    assign route_audio = ctrl_reg[`TSG_CTRL_ROUTE_BIT];
    assign preemp_on = ctrl_reg[`TSG_CTRL_PREEMP_BIT];
    assign wr_en = clk_en && psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    assign send_cmd = wr_en && paddr == `TSG_OFF_CMD && pwdata[`TSG_CMD_SEND_BIT];
    assign stop_cmd = wr_en && paddr == `TSG_OFF_CMD && pwdata[`TSG_CMD_STOP_BIT];
    assign tick = tick_reg == TICK_M1;
    assign last_pos = {1'b0, pos_reg} >= len_reg - 5'h01;
    assign cur_sym = seq_reg[pos_reg];
    assign pready = 1'b1;

    // decode of mapped addresses
    always_comb begin
        addr_ok = 1'b0;
        if (paddr[1:0] == 2'h0) begin
            unique case (paddr[11:6])
                6'h00: addr_ok = paddr[5:2] <= 4'h5;
                6'h04, 6'h05, 6'h06: addr_ok = 1'b1;
                default: addr_ok = 1'b0;
            endcase
        end
    end
    assign pslverr = psel && penable && !addr_ok;

    // control, level, length and standard registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TSG_CTRL_RST;
            level_reg <= `TSG_LEVEL_RST;
            len_reg <= `TSG_LEN_RST;
            std_reg <= 2'h0;
            std_load_reg <= 1'b1;
        end else if (clk_en) begin
            std_load_reg <= 1'b0;
            if (wr_en) begin
                unique case (paddr)
                    `TSG_OFF_CTRL: ctrl_reg <= pwdata;
                    `TSG_OFF_LEVEL: level_reg <= pwdata[7:0];
                    `TSG_OFF_LEN: len_reg <= (pwdata[4:0] > 5'h10) ? 5'h10 : pwdata[4:0];
                    `TSG_OFF_STD: begin
                        std_reg <= pwdata[1:0];
                        std_load_reg <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // preset frequency per standard and symbol
    function automatic logic [15:0] tsg_preset(input logic [1:0] s, input logic [3:0] i);
        logic [15:0] base;
        logic [15:0] step;
        base = 16'h0190 + {12'h000, s, 2'h0} * 16'h0040;
        step = 16'h0050 + {14'h0000, s} * 16'h0008;
        tsg_preset = base + 16'(step * {12'h000, i});
    endfunction : tsg_preset

    // symbol list, per-position times and tone definitions
    always_ff @(posedge pclk) begin
        if (clk_en) begin
            for (int k = 0; k < 16; k++) begin
                if (std_load_reg) begin
                    def_reg[k].freq <= tsg_preset(std_reg, 4'(k));
                end
            end
            if (wr_en && paddr[11:6] == 6'h04) begin
                seq_reg[paddr[5:2]] <= pwdata[3:0];
            end
            if (wr_en && paddr[11:6] == 6'h05) begin
                time_reg[paddr[5:2]] <= pwdata;
            end
            if (wr_en && paddr[11:6] == 6'h06) begin
                def_reg[paddr[5:2]] <= pwdata[23:0];
            end
        end
    end

    // read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && rd_en && !penable) begin
            prdata <= 32'h0000_0000;
            unique case (paddr[11:6])
                6'h00: begin
                    unique case (paddr[5:2])
                        4'h0: prdata <= ctrl_reg;
                        4'h2: prdata <= {22'h0, burst_left_reg, state_reg};
                        4'h3: prdata <= {24'h0, level_reg};
                        4'h4: prdata <= {27'h0, len_reg};
                        4'h5: prdata <= {30'h0, std_reg};
                        default: prdata <= {28'h0, pos_reg};
                    endcase
                end
                6'h04: prdata <= {28'h0, seq_reg[paddr[5:2]]};
                6'h05: prdata <= time_reg[paddr[5:2]];
                6'h06: prdata <= {8'h0, def_reg[paddr[5:2]]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // timebase for on/off durations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= 32'h0;
        end else if (clk_en) begin
            tick_reg <= (tick || state_reg == TSG_IDLE) ? 32'h0 : tick_reg + 32'h1;
        end
    end

    // sequencer state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TSG_IDLE;
            pos_reg <= 4'h0;
            burst_left_reg <= 8'h0;
            dur_reg <= 16'h0;
        end else if (clk_en) begin
            if (stop_cmd) begin
                state_reg <= TSG_IDLE;
                pos_reg <= 4'h0;
            end else begin
                unique case (state_reg)
                    TSG_IDLE: begin
                        if (send_cmd && len_reg != 5'h00) begin
                            state_reg <= TSG_ON;
                            dur_reg <= time_reg[pos_reg].on_time;
                            if (mode != TSG_STEP) begin
                                pos_reg <= 4'h0;
                                dur_reg <= time_reg[0].on_time;
                            end
                            // burst count loaded from ctrl in burst mode, set to 1 in other modes
                            burst_left_reg <= (mode == TSG_BURST) ?
                                ctrl_reg[`TSG_CTRL_BURST_LSB +: 8] : 8'h01;
                        end
                    end
                    TSG_ON: begin
                        if (tick) begin
                            if (dur_reg <= 16'h0001) begin
                                state_reg <= TSG_OFF;
                                dur_reg <= time_reg[pos_reg].off_time;
                            end else begin
                                dur_reg <= dur_reg - 16'h1;
                            end
                        end
                    end
                    TSG_OFF: begin
                        if (tick) begin
                            if (dur_reg > 16'h0001) begin
                                dur_reg <= dur_reg - 16'h1;
                            end else if (mode == TSG_STEP) begin
                                state_reg <= TSG_IDLE;
                                pos_reg <= last_pos ? 4'h0 : pos_reg + 4'h1;
                            end else if (!last_pos) begin
                                pos_reg <= pos_reg + 4'h1;
                                dur_reg <= time_reg[pos_reg + 4'h1].on_time;
                                state_reg <= TSG_ON;
                            end else if (mode == TSG_CONT ||
                                    (mode == TSG_BURST && burst_left_reg > 8'h01)) begin
                                pos_reg <= 4'h0;
                                dur_reg <= time_reg[0].on_time;
                                state_reg <= TSG_ON;
                                if (mode == TSG_BURST) begin
                                    burst_left_reg <= burst_left_reg - 8'h01;
                                end
                            end else begin
                                state_reg <= TSG_IDLE;
                                pos_reg <= 4'h0;
                            end
                        end
                    end
                    default: state_reg <= TSG_IDLE;
                endcase
            end
        end
    end

    // amplitude: percent of master level
    assign scaled_amp = 16'(({8'h0, level_reg} * {8'h0, def_reg[cur_sym].amp}) / 16'd100);

    // frequency and amplitude of the current tone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_reg <= 16'h0;
            freq_reg <= 16'h0;
        end else if (clk_en) begin
            freq_reg <= def_reg[cur_sym].freq;
            amp_reg <= (state_reg == TSG_ON && level_reg != 8'h00) ? scaled_amp : 16'h0;
        end
    end

    // first-order pre-emphasis: boost by amplitude minus slow average
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_acc_reg <= 32'h0;
        end else if (clk_en) begin
            pe_acc_reg <= pe_acc_reg + {16'h0, amp_reg} - (pe_acc_reg >> PE_SHIFT);
        end
    end

    always_comb begin
        logic [16:0] boosted;
        logic [15:0] avg;
        avg = 16'(pe_acc_reg >> PE_SHIFT);
        boosted = {1'b0, amp_reg} + ((amp_reg > avg) ? {1'b0, amp_reg - avg} : 17'h0);
        if (!preemp_on) begin
            amp_fin = amp_reg;
        end else begin
            amp_fin = boosted[16] ? 16'hFFFF : boosted[15:0];
        end
    end

    // registered output tone; valid delayed one stage to line up with freq and amp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_reg <= '0;
            on_q_reg <= 1'b0;
        end else if (clk_en) begin
            on_q_reg <= state_reg == TSG_ON;
            tone_reg.valid <= on_q_reg;
            tone_reg.freq <= freq_reg;
            tone_reg.amp <= amp_fin;
        end
    end

    // routing: exactly one destination carries the tone
    assign rf_mod_out = route_audio ? '0 : tone_reg;
    assign audio_out = route_audio ? tone_reg : '0;
    assign busy = state_reg != TSG_IDLE;
endmodule : tsg_top

// ### tb/tb_tsg_top.sv
`timescale 1ns/1ps
`include "tsg_cfg.svh"
module tb_tsg_top;
    import tsg_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tsg_tone_s rf_mod_out;
    tsg_tone_s audio_out;
    logic busy;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int tcnt = 0;
    logic tv_q = 1'b0;
    tsg_tone_s tones [0:63];
    logic [31:0] rd;
    logic err;
    tsg_top #(.TICK_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rf_mod_out(rf_mod_out),
        .audio_out(audio_out), .busy(busy));
    // clock
    always #2 pclk = ~pclk;
    // hang guard and tone logger
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            finish_test();
        end
        tv_q <= rf_mod_out.valid | audio_out.valid;
        if ((rf_mod_out.valid | audio_out.valid) && !tv_q) begin
            tones[tcnt[5:0]] <= rf_mod_out.valid ? rf_mod_out : audio_out;
            tcnt <= tcnt + 1;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic run(input logic [31:0] ctrl, input int n);
        apb(1'b1, `TSG_OFF_CTRL, ctrl);
        tcnt = 0;
        apb(1'b1, `TSG_OFF_CMD, 32'h0000_0001);
        @(posedge pclk);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge pclk);
        chk("tone count", n, tcnt);
    endtask : run
    task automatic end_test(input string n);
        $display("test %s done", n);
    endtask : end_test
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, `TSG_OFF_CTRL, 0);
        chk("ctrl", 32'h0000_0100, rd);
        apb(1'b0, `TSG_OFF_LEN, 0);
        chk("len", 32'h0000_0010, rd);
        apb(1'b0, 12'h018, 0);
        chk("unmapped err", 1, {31'h0, err});
        end_test("registers");
        apb(1'b1, `TSG_OFF_LEN, 3);
        apb(1'b1, `TSG_OFF_LEVEL, 32'h0000_00C8);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `TSG_OFF_SEQ + 12'(4 * i), 5 + 5 * i);
            apb(1'b1, `TSG_OFF_TIME + 12'(4 * i), 32'h0001_0001);
            apb(1'b1, `TSG_OFF_DEF + 12'(20 + 20 * i), 32'h0010_0532 + 32'(1280 * i));
            apb(1'b0, `TSG_OFF_DEF + 12'(20 + 20 * i), 0);
            chk("def", 32'h0010_0532 + 32'(1280 * i), rd);
        end
        run(32'h0000_0003, 1);
        run(32'h0000_0003, 1);
        chk("step freq", 16'h100A, tones[0].freq);
        end_test("step");
        run(32'h0000_0300, 3);
        for (int i = 0; i < 3; i++) begin
            chk("freq", 16'h1005 + 16'(5 * i), tones[i].freq);
            chk("amp", 16'h0064, tones[i].amp);
        end
        end_test("single");
        run(32'h0000_0209, 6);
        chk("preemp amp", 32'h0000_00C8, tones[0].amp);
        end_test("burst");
        apb(1'b1, `TSG_OFF_CTRL, 32'h0000_0106);
        tcnt = 0;
        apb(1'b1, `TSG_OFF_CMD, 32'h0000_0001);
        for (int i = 0; i < 4000 && tcnt < 5; i++) @(posedge pclk);
        chk("wrap", 1, {31'h0, tcnt >= 5});
        chk("rf idle", 0, {31'h0, rf_mod_out.valid});
        chk("audio amp", 16'h0064, tones[3].amp);
        apb(1'b1, `TSG_OFF_CMD, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        chk("stopped", 0, {31'h0, busy});
        repeat (3) @(posedge pclk);
        chk("silent", 0, {31'h0, audio_out.valid});
        end_test("continuous");
        apb(1'b1, `TSG_OFF_LEVEL, 0);
        run(32'h0000_0000, 3);
        chk("off amp", 0, tones[1].amp);
        end_test("level");
        finish_test();
    end
endmodule : tb_tsg_top

// ### tb/tsg_top_assertions.sv
`timescale 1ns/1ps
`include "tsg_cfg.svh"
module tsg_top_checker
    import tsg_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tsg_tone_s rf_mod_out,
    input wire tsg_tone_s audio_out,
    input wire logic busy
);
    logic wr_en;
    logic cmd_wr;
    logic tv;
    logic route_q;
    logic [7:0] level_q;
    logic [15:0] on_cnt;
    // accepted writes and any tone present
    assign wr_en = psel && penable && pwrite && clk_en;
    assign cmd_wr = wr_en && paddr == `TSG_OFF_CMD;
    assign tv = rf_mod_out.valid || audio_out.valid;
    // mirror of route and level settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_q <= 1'b0;
            level_q <= 8'h00;
        end else if (wr_en && paddr == `TSG_OFF_CTRL) begin
            route_q <= pwdata[2];
        end else if (wr_en && paddr == `TSG_OFF_LEVEL) begin
            level_q <= pwdata[7:0];
        end
    end
    // length of the current tone in cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= 16'h0000;
        end else begin
            on_cnt <= tv ? on_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_route_excl: assert property (!(rf_mod_out.valid && audio_out.valid))
        else $error("tone on both outputs");
    a_route_sel: assert property (tv |-> audio_out.valid == route_q)
        else $error("tone on wrong output");
    a_idle_silent: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> !tv)
        else $error("tone while idle");
    a_stop_ends: assert property (cmd_wr && pwdata[1] |-> ##[1:3] !busy)
        else $error("stop did not end run");
    a_send_starts: assert property (cmd_wr && pwdata[0] && !pwdata[1] && !busy
        |-> ##[1:3] busy)
        else $error("send did not start run");
    a_level_off: assert property (tv && level_q == 8'h00
        |-> (rf_mod_out.amp | audio_out.amp) == 16'h0000)
        else $error("sound at level off");
    a_on_min: assert property ($fell(tv) && busy |-> on_cnt >= TICK_CYC)
        else $error("tone too short");
    a_off_gap: assert property ($fell(tv) && busy |-> !tv [*3])
        else $error("no gap after tone");
    c_audio: cover property ($rose(audio_out.valid));
    c_rf: cover property ($rose(rf_mod_out.valid));
    c_stop: cover property (cmd_wr && pwdata[1] && busy);
endmodule : tsg_top_checker

bind tsg_top tsg_top_checker #(.TICK_CYC(TICK_CYC)) u_chk (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rf_mod_out, .audio_out,
    .busy);
